// file: mvr_core.sv
// Move, literal load, no-operation and interrupt return execution unit
//
// Notes on behaviour
// - load_file_value moves f to acc if d=0, else to f, in one cycle.
// - load_file_value sets zero_flag from the moved byte; d=1 tests f.
// - store_acc_to_file writes acc into f in one cycle, flags untouched.
// - load_literal puts 8-bit k into acc in one cycle, flags untouched.
// - irq_return pops the stack, loading the popped stack_head into pc.
// - irq_return sets global_irq_allow, bit 7 of irq_control_reg.
// - irq_return is one word and takes two instruction cycles.
`timescale 1ns/10ps
`include "mvr_defs.svh"
module mvr_core (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [`MVR_OP_W-1:0] instr_op,
    input wire logic [`MVR_ADDR_W-1:0] instr_file,
    input wire logic instr_dest,
    input wire logic [`MVR_DATA_W-1:0] instr_lit,
    input wire logic [`MVR_PC_W-1:0] stack_head,
    input wire logic irq_taken,
    output logic instr_ready,
    output logic [`MVR_DATA_W-1:0] acc,
    output logic zero_flag,
    output logic [`MVR_PC_W-1:0] pc,
    output logic [`MVR_DATA_W-1:0] irq_control_reg,
    output logic stack_pop,
    output logic file_wr_en,
    output logic [`MVR_ADDR_W-1:0] file_wr_addr,
    output logic [`MVR_DATA_W-1:0] file_wr_data
);
    ////////////////////////////////////////////////////////////////////////
    // Execute stage registers
    logic ex_valid_r;
    mvr_pkg::mvr_op_t ex_op_r;
    logic [`MVR_ADDR_W-1:0] ex_file_r;
    logic ex_dest_r;
    logic [`MVR_DATA_W-1:0] ex_lit_r;
    mvr_pkg::mvr_state_t state_r;
    mvr_pkg::mvr_state_t state_nxt;
    logic instr_ready_r;
    logic [`MVR_DATA_W-1:0] acc_r;
    logic zero_flag_r;
    logic [`MVR_PC_W-1:0] pc_r;
    logic [`MVR_DATA_W-1:0] irq_ctrl_r;
    logic stack_pop_r;
    logic file_wr_en_r;
    logic [`MVR_ADDR_W-1:0] file_wr_addr_r;
    logic [`MVR_DATA_W-1:0] file_wr_data_r;
    logic accept;
    logic ex_run;
    logic [`MVR_DATA_W-1:0] file_val;
    logic mem_wr;

    mvr_mem_if mif ();

    mvr_file_mem u_mem (
        .ref_clk(ref_clk),
        .mem(mif.mem)
    );

    function automatic logic is_op(input mvr_pkg::mvr_op_t op,
                                   input mvr_pkg::mvr_op_t want);
        is_op = (op == want);
    endfunction

    assign accept = instr_valid && instr_ready_r;
    assign ex_run = ex_valid_r && (state_r == mvr_pkg::MVR_ST_RUN);
    assign file_val = mif.rd_data;

    // Read is issued as the instruction is taken, data ready in execute
    assign mif.rd_addr = instr_file;
    assign mem_wr = ex_run
        && ((is_op(ex_op_r, mvr_pkg::MVR_OP_LOAD_FILE) && ex_dest_r)
        || is_op(ex_op_r, mvr_pkg::MVR_OP_STORE_ACC));
    assign mif.wr_en = mem_wr;
    assign mif.wr_addr = ex_file_r;
    assign mif.wr_data = is_op(ex_op_r, mvr_pkg::MVR_OP_STORE_ACC)
        ? acc_r : file_val;

    ////////////////////////////////////////////////////////////////////////
    // Instruction capture
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ex_valid_r <= 1'b0;
            ex_op_r <= mvr_pkg::MVR_OP_NOP;
            ex_file_r <= {`MVR_ADDR_W{1'b0}};
            ex_dest_r <= 1'b0;
            ex_lit_r <= `MVR_ACC_RST;
        end else begin
            ex_valid_r <= accept;
            if (accept) begin
                // Codes outside the set run as a no-operation
                case (instr_op)
                    mvr_pkg::MVR_OP_LOAD_FILE,
                    mvr_pkg::MVR_OP_STORE_ACC,
                    mvr_pkg::MVR_OP_LOAD_LIT,
                    mvr_pkg::MVR_OP_IRQ_RETURN: begin
                        ex_op_r <= mvr_pkg::mvr_op_t'(instr_op);
                    end
                    default: begin
                        ex_op_r <= mvr_pkg::MVR_OP_NOP;
                    end
                endcase
                ex_file_r <= instr_file;
                ex_dest_r <= instr_dest;
                ex_lit_r <= instr_lit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-cycle sequencing of the return
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mvr_pkg::MVR_ST_RUN: begin
                if (ex_run && is_op(ex_op_r, mvr_pkg::MVR_OP_IRQ_RETURN)) begin
                    state_nxt = mvr_pkg::MVR_ST_RELOAD;
                end
            end
            mvr_pkg::MVR_ST_RELOAD: begin
                state_nxt = mvr_pkg::MVR_ST_RUN;
            end
            default: begin
                state_nxt = mvr_pkg::MVR_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= mvr_pkg::MVR_ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Refuse a new word while the PC reload occupies the second cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            instr_ready_r <= 1'b1;
        end else if (accept
                     && is_op(mvr_pkg::mvr_op_t'(instr_op),
                              mvr_pkg::MVR_OP_IRQ_RETURN)) begin
            instr_ready_r <= 1'b0;
        end else if (ex_run
                     && is_op(ex_op_r, mvr_pkg::MVR_OP_IRQ_RETURN)) begin
            // Reopen as the reload starts, so only one word is refused
            instr_ready_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator and zero flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            acc_r <= `MVR_ACC_RST;
        end else if (ex_run) begin
            if (is_op(ex_op_r, mvr_pkg::MVR_OP_LOAD_FILE) && !ex_dest_r) begin
                acc_r <= file_val;
            end else if (is_op(ex_op_r, mvr_pkg::MVR_OP_LOAD_LIT)) begin
                acc_r <= ex_lit_r;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            zero_flag_r <= 1'b0;
        end else if (ex_run && is_op(ex_op_r, mvr_pkg::MVR_OP_LOAD_FILE)) begin
            zero_flag_r <= (file_val == `MVR_ZERO_BYTE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter and stack
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pc_r <= `MVR_PC_RST;
        end else if (ex_run) begin
            if (is_op(ex_op_r, mvr_pkg::MVR_OP_IRQ_RETURN)) begin
                pc_r <= stack_head;
            end else begin
                pc_r <= pc_r + `MVR_PC_STEP;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stack_pop_r <= 1'b0;
        end else begin
            stack_pop_r <= ex_run
                && is_op(ex_op_r, mvr_pkg::MVR_OP_IRQ_RETURN);
        end
    end

    // Return wins over an interrupt entry in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_ctrl_r <= `MVR_IRQ_CTRL_RST;
        end else if (ex_run
                     && is_op(ex_op_r, mvr_pkg::MVR_OP_IRQ_RETURN)) begin
            irq_ctrl_r[`MVR_GLOBAL_IRQ_BIT] <= 1'b1;
        end else if (irq_taken) begin
            irq_ctrl_r[`MVR_GLOBAL_IRQ_BIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered copy of file writes for observers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            file_wr_en_r <= 1'b0;
            file_wr_addr_r <= {`MVR_ADDR_W{1'b0}};
            file_wr_data_r <= `MVR_ZERO_BYTE;
        end else begin
            file_wr_en_r <= mem_wr;
            file_wr_addr_r <= ex_file_r;
            file_wr_data_r <= mif.wr_data;
        end
    end

    assign instr_ready = instr_ready_r;
    assign acc = acc_r;
    assign zero_flag = zero_flag_r;
    assign pc = pc_r;
    assign irq_control_reg = irq_ctrl_r;
    assign stack_pop = stack_pop_r;
    assign file_wr_en = file_wr_en_r;
    assign file_wr_addr = file_wr_addr_r;
    assign file_wr_data = file_wr_data_r;
endmodule // mvr_core

// file: mvr_defs.svh
// Widths, reset values and bit positions for the move and return unit
`ifndef MVR_DEFS_SVH
`define MVR_DEFS_SVH
`define MVR_DATA_W 8
`define MVR_ADDR_W 7
`define MVR_DEPTH 128
`define MVR_PC_W 13
`define MVR_OP_W 3
`define MVR_GLOBAL_IRQ_BIT 7
`define MVR_IRQ_CTRL_RST 8'h00
`define MVR_PC_RST 13'h0000
`define MVR_PC_STEP 13'h0001
`define MVR_ACC_RST 8'h00
`define MVR_ZERO_BYTE 8'h00
`endif

// file: mvr_pkg.sv
// Types shared by the move and return unit
package mvr_pkg;
    typedef enum logic [2:0] {
        MVR_OP_NOP = 3'b000,
        MVR_OP_LOAD_FILE = 3'b001,
        MVR_OP_STORE_ACC = 3'b010,
        MVR_OP_LOAD_LIT = 3'b011,
        MVR_OP_IRQ_RETURN = 3'b100
    } mvr_op_t;

    typedef enum logic [1:0] {
        MVR_ST_RUN = 2'b00,
        MVR_ST_RELOAD = 2'b01
    } mvr_state_t;
endpackage

// file: mvr_mem_if.sv
// File register port between the core and its storage
`timescale 1ns/10ps
`include "mvr_defs.svh"
interface mvr_mem_if;
    logic [`MVR_ADDR_W-1:0] rd_addr;
    logic [`MVR_DATA_W-1:0] rd_data;
    logic wr_en;
    logic [`MVR_ADDR_W-1:0] wr_addr;
    logic [`MVR_DATA_W-1:0] wr_data;
    modport core (output rd_addr, input rd_data, output wr_en,
                  output wr_addr, output wr_data);
    modport mem (input rd_addr, output rd_data, input wr_en,
                 input wr_addr, input wr_data);
endinterface

// file: mvr_file_mem.sv
// File register storage, 128 bytes, registered read, write-first
`timescale 1ns/10ps
`include "mvr_defs.svh"
module mvr_file_mem (
    input wire logic ref_clk,
    mvr_mem_if.mem mem
);
    logic [`MVR_DATA_W-1:0] cells [`MVR_DEPTH];
    logic [`MVR_DATA_W-1:0] rd_data_r;

    always_ff @(posedge ref_clk) begin
        if (mem.wr_en) begin
            cells[mem.wr_addr] <= mem.wr_data;
        end
    end

    // Back-to-back write then read of one address must see the new byte
    always_ff @(posedge ref_clk) begin
        if (mem.wr_en && (mem.wr_addr == mem.rd_addr)) begin
            rd_data_r <= mem.wr_data;
        end else begin
            rd_data_r <= cells[mem.rd_addr];
        end
    end

    assign mem.rd_data = rd_data_r;
endmodule // mvr_file_mem

// file: mvr_core_properties.sv
// Port-level checks of the move and return unit
`timescale 1ns/10ps
`include "mvr_defs.svh"
module mvr_core_properties (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [`MVR_OP_W-1:0] instr_op,
    input wire logic [`MVR_ADDR_W-1:0] instr_file,
    input wire logic instr_dest,
    input wire logic [`MVR_DATA_W-1:0] instr_lit,
    input wire logic [`MVR_PC_W-1:0] stack_head,
    input wire logic irq_taken,
    input wire logic instr_ready,
    input wire logic [`MVR_DATA_W-1:0] acc,
    input wire logic zero_flag,
    input wire logic [`MVR_PC_W-1:0] pc,
    input wire logic [`MVR_DATA_W-1:0] irq_control_reg,
    input wire logic stack_pop,
    input wire logic file_wr_en,
    input wire logic [`MVR_ADDR_W-1:0] file_wr_addr,
    input wire logic [`MVR_DATA_W-1:0] file_wr_data
);
    logic tk;
    logic tk_ret;
    assign tk = instr_valid && instr_ready;
    assign tk_ret = tk && instr_op == mvr_pkg::MVR_OP_IRQ_RETURN;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    chk_lit_load: assert property (
        tk && instr_op == mvr_pkg::MVR_OP_LOAD_LIT
        |-> ##2 acc == $past(instr_lit, 2) && $stable(zero_flag))
        else $error("literal load wrong");
    chk_file_acc: assert property (
        tk && instr_op == mvr_pkg::MVR_OP_LOAD_FILE && !instr_dest
        |-> ##2 zero_flag == (acc == `MVR_ZERO_BYTE))
        else $error("file to acc zero flag wrong");
    chk_file_self: assert property (
        tk && instr_op == mvr_pkg::MVR_OP_LOAD_FILE && instr_dest
        |-> ##2 $stable(acc) && file_wr_en
        && file_wr_addr == $past(instr_file, 2))
        else $error("file self copy wrong");
    chk_store_write: assert property (
        tk && instr_op == mvr_pkg::MVR_OP_STORE_ACC
        |-> ##2 $stable(zero_flag) && file_wr_en
        && file_wr_addr == $past(instr_file, 2)
        && file_wr_data == $past(acc))
        else $error("store write wrong");
    chk_ret_ready: assert property (
        tk_ret |=> !instr_ready ##1 instr_ready)
        else $error("return not two cycles");
    chk_ret_pc: assert property (
        tk_ret |-> ##2 pc == $past(stack_head) && stack_pop
        && irq_control_reg[`MVR_GLOBAL_IRQ_BIT] ##1 !stack_pop)
        else $error("return pc or enable wrong");
    chk_pop_cause: assert property (
        $rose(stack_pop) |-> $past(tk_ret, 2))
        else $error("stray stack pop");
    chk_nop_pc: assert property (
        tk && instr_op == mvr_pkg::MVR_OP_NOP
        |-> ##2 pc == $past(pc) + `MVR_PC_STEP && $stable(acc)
        && $stable(zero_flag))
        else $error("nop changed state");
    cover property (tk_ret);
    cover property (tk && instr_op == mvr_pkg::MVR_OP_STORE_ACC);
    cover property (tk && instr_op == mvr_pkg::MVR_OP_LOAD_FILE && instr_dest);
endmodule // mvr_core_properties
bind mvr_core mvr_core_properties mvr_core_properties_i (.*);

// file: test_move_and_return_ops.sv
// Self-checking bench for the move and return unit
`timescale 1ns/10ps
`include "mvr_defs.svh"
module test_move_and_return_ops;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [2:0] instr_op = 3'h0;
    logic [6:0] instr_file = 7'h00;
    logic instr_dest = 1'b0;
    logic [7:0] instr_lit = 8'h00;
    logic [12:0] stack_head = 13'h1ABC;
    logic irq_taken = 1'b0;
    logic instr_ready, zero_flag, stack_pop, file_wr_en;
    logic [7:0] acc, irq_control_reg, file_wr_data;
    logic [12:0] pc;
    logic [6:0] file_wr_addr;
    logic [7:0] m_acc = 8'h00;
    logic [7:0] m_mem [128];
    logic m_z = 1'b0;
    logic [12:0] m_pc = 13'h0000;
    int waits;
    int n_mismatch = 0;
    int n_tests = 0;
    always #10 ref_clk = ~ref_clk;
    mvr_core mvr_core_i (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [12:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Valid stays high on return so a following call runs back to back
    task automatic issue(input logic [2:0] op, input logic [6:0] f,
                         input logic d, input logic [7:0] k);
        logic t;
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_file <= f;
        instr_dest <= d;
        instr_lit <= k;
        for (waits = 0; waits < 8; waits++) begin
            @(negedge ref_clk);
            t = instr_ready;
            @(posedge ref_clk);
            if (t) begin
                if (op == 3'h3) m_acc = k;
                if (op == 3'h2) m_mem[f] = m_acc;
                if (op == 3'h1) m_z = m_mem[f] == 8'h00;
                if (op == 3'h1 && !d) m_acc = m_mem[f];
                m_pc = op == 3'h4 ? stack_head : m_pc + 13'h0001;
                return;
            end
        end
        n_mismatch++;
        tally_and_finish();
    endtask
    task automatic fin();
        instr_valid <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        cmp("acc", {5'h00, m_acc}, {5'h00, acc});
        cmp("zero", {12'h000, m_z}, {12'h000, zero_flag});
        cmp("pc", m_pc, pc);
        @(posedge ref_clk);
    endtask
    task automatic s_literal();
        logic [7:0] ks [3] = '{8'h00, 8'h5A, 8'hFF};
        foreach (ks[i]) begin
            issue(3'h3, 7'h00, 1'b0, ks[i]);
            fin();
        end
    endtask
    task automatic s_move();
        issue(3'h3, 7'h00, 1'b0, 8'h3C);
        issue(3'h2, 7'h7F, 1'b0, 8'h00);
        issue(3'h3, 7'h00, 1'b0, 8'h00);
        issue(3'h2, 7'h00, 1'b0, 8'h00);
        issue(3'h3, 7'h00, 1'b0, 8'h77);
        issue(3'h1, 7'h00, 1'b1, 8'h00);
        fin();
        issue(3'h1, 7'h7F, 1'b0, 8'h00);
        fin();
    endtask
    task automatic s_nop();
        issue(3'h0, 7'h15, 1'b1, 8'hC3);
        issue(3'h7, 7'h15, 1'b1, 8'hC3);
        fin();
    endtask
    task automatic s_irq();
        issue(3'h4, 7'h00, 1'b0, 8'h00);
        issue(3'h3, 7'h00, 1'b0, 8'h11);
        cmp("refused", 13'h0001, waits[12:0]);
        fin();
        cmp("enable", 13'h0080, {5'h00, irq_control_reg});
        irq_taken <= 1'b1;
        @(posedge ref_clk);
        irq_taken <= 1'b0;
        @(negedge ref_clk);
        cmp("enable", 13'h0000, {5'h00, irq_control_reg});
        @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        fin();
        @(negedge ref_clk);
        cmp("ready", 13'h0001, {12'h000, instr_ready});
        @(posedge ref_clk);
        s_literal();
        s_move();
        s_nop();
        s_irq();
        tally_and_finish();
    end
endmodule // test_move_and_return_ops
